/* inc/lsb_defs.vh */
`ifndef LSB_DEFS_VH
`define LSB_DEFS_VH

// register byte offsets on the wishbone slave
`define LSB_OFS_CTRL      8'h00
`define LSB_OFS_INSTR     8'h04
`define LSB_OFS_COUNT     8'h08
`define LSB_OFS_EQIDX     8'h0C
`define LSB_OFS_STATUS    8'h10
`define LSB_OFS_CYCLES    8'h14

// ctrl fields
`define LSB_CTRL_START    0
`define LSB_CTRL_NARROW   1
// instr fields
`define LSB_INSTR_PFX_LO  0
`define LSB_INSTR_OP_LO   8
`define LSB_INSTR_MRM_LO  16
`define LSB_INSTR_PFX_VLD 24
// status fields
`define LSB_ST_BUSY       0
`define LSB_ST_DONE       1
`define LSB_ST_ILLEGAL    2
`define LSB_ST_TERM       3
`define LSB_ST_CLASS_LO   4
`define LSB_ST_WORD       8
`define LSB_ST_MEM        9
`define LSB_ST_DIR        10
`define LSB_ST_REP        11

// reset values
`define LSB_RST_CTRL      2'h0
`define LSB_RST_INSTR     25'h0000000
`define LSB_RST_COUNT     16'h0000
`define LSB_RST_EQIDX     16'h0000

// operation classes
`define LSB_CL_ILL        4'h0
`define LSB_CL_XOR_RM     4'h1
`define LSB_CL_XOR_IRM    4'h2
`define LSB_CL_XOR_IACC   4'h3
`define LSB_CL_INVERT     4'h4
`define LSB_CL_MOVE       4'h5
`define LSB_CL_COMPARE    4'h6
`define LSB_CL_SCAN       4'h7
`define LSB_CL_LOAD       4'h8
`define LSB_CL_STORE      4'h9
`define LSB_CL_INPUT      4'hA
`define LSB_CL_OUTPUT     4'hB
`define LSB_CL_CALL_IND   4'hC
`define LSB_CL_JMP_SHORT  4'hD
`define LSB_CL_JMP_NEAR   4'hE
`define LSB_CL_JMP_IND    4'hF

// timing counts in processor clocks
`define LSB_T_LOGIC_REG   8'h03
`define LSB_T_LOGIC_MEM   8'h0A
`define LSB_T_IMM_REG     8'h04
`define LSB_T_IMM_MEM     8'h10
`define LSB_T_ACC_BYTE    8'h03
`define LSB_T_ACC_WORD    8'h04
`define LSB_T_MOVE        8'h0E
`define LSB_T_COMPARE     8'h16
`define LSB_T_SCAN        8'h0F
`define LSB_T_LOAD        8'h0C
`define LSB_T_STORE       8'h0A
`define LSB_T_INOUT       8'h0E
`define LSB_T_REP_MOVE_B  8'h08
`define LSB_T_REP_MOVE_E  8'h08
`define LSB_T_REP_CMP_B   8'h05
`define LSB_T_REP_CMP_E   8'h16
`define LSB_T_REP_SCAN_E  8'h0F
`define LSB_T_REP_LS_B    8'h06
`define LSB_T_REP_LOAD_E  8'h0B
`define LSB_T_REP_STORE_E 8'h09
`define LSB_T_CALL_REG_W  8'h0D
`define LSB_T_CALL_MEM_W  8'h13
`define LSB_T_CALL_REG_N  8'h11
`define LSB_T_CALL_MEM_N  8'h1B
`define LSB_T_JMP         8'h0E
`define LSB_T_JIND_REG    8'h0B
`define LSB_T_JIND_MEM_W  8'h11
`define LSB_T_JIND_MEM_N  8'h15
`define LSB_T_WORD_XFER   8'h04

`endif

/* logic/lsb_timer.v */
`default_nettype none

// down-counter: counts val_i cycles after load_i, flags the last of them
module lsb_timer (
   input  wire       clk_i,
   input  wire       rst_i,
   input  wire       load_i,
   input  wire [7:0] val_i,
   output wire       last_o
);
   reg [7:0] cnt_r;

   // a load in the last cycle restarts at once, so elements run back to back
   always @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= 8'h00;
      end else if (load_i) begin
         cnt_r <= val_i;
      end else if (cnt_r != 8'h00) begin
         cnt_r <= cnt_r - 8'h01;
      end
   end

   assign last_o = (cnt_r == 8'h01);
endmodule

`default_nettype wire

/* logic/lsb_decoder.v */
// Chosen here: the Wishbone slave port and the address map.
`include "lsb_defs.vh"
`default_nettype none

// Summary of operation
// - exclusive-or decoded in three forms; register/memory form takes 3 or 10 cycles
// - invert decoded from 1111011w with extension 010; 3 register, 10 memory cycles
// - 1010010w is a single string move taking 14 cycles
// - 1010011w is a single string compare taking 22 cycles
// - 1010111w is a single string scan of accumulator taking 15 cycles
// - 1010110w is a single string load into accumulator taking 12 cycles
// - 1010101w is a single string store from accumulator taking 10 cycles
// - 0110110w is string input from the port pointer taking 14 cycles
// - 0110111w is string output to the port pointer taking 14 cycles
// - repeat prefix repeats count times; z bit picks termination; move/in/out 8+8n
// - 11111111 extension 010 is indirect near call: 13/19, or 17/27 narrow
// - jumps 11101011 and 11101001 take 14; 11111111 extension 100 is indirect
// - on the narrow bus, word operations add 4 cycles per memory transfer
module lsb_decoder (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   output reg         busy_o
);
   localparam ST_IDLE = 2'b00;
   localparam ST_BASE = 2'b01;
   localparam ST_ELEM = 2'b10;

   reg [1:0]  state_r;
   reg [1:0]  state_nxt;
   reg        narrow_r;
   reg [24:0] instr_r;
   reg [15:0] count_r;
   reg [15:0] eqidx_r;
   reg [15:0] elem_idx_r;
   reg        done_r;
   reg        illegal_r;
   reg        term_r;
   reg [31:0] cycles_r;
   reg [3:0]  run_class_r;
   reg        run_rep_r;
   reg        run_z_r;
   reg [7:0]  run_elem_r;

   wire       wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire       wb_wr   = wb_req & wb_we_i;
   wire       start   = wb_wr & (wb_adr_i == `LSB_OFS_CTRL) & wb_sel_i[0]
                        & wb_dat_i[`LSB_CTRL_START] & (state_r == ST_IDLE);
   wire [7:0] pfx     = instr_r[`LSB_INSTR_PFX_LO +: 8];
   wire [7:0] op      = instr_r[`LSB_INSTR_OP_LO +: 8];
   wire [7:0] mrm     = instr_r[`LSB_INSTR_MRM_LO +: 8];
   wire       pfx_vld = instr_r[`LSB_INSTR_PFX_VLD];
   wire       mem     = (mrm[7:6] != 2'b11);
   wire [2:0] ext     = mrm[5:3];
   wire       w_bit   = op[0];
   wire       d_bit   = op[1];

   reg [3:0]  cls;
   reg [7:0]  t_single;
   reg [7:0]  t_rbase;
   reg [7:0]  t_relem;
   reg [1:0]  xfers;
   reg        starred;
   reg        is_string;
   reg        is_cmp;
   reg [7:0]  pen;
   reg        repeat_prefix;
   reg [7:0]  base_val;

   // opcode and mode byte decode with cycle figures for both bus widths
   always @* begin
      cls       = `LSB_CL_ILL;
      t_single  = 8'h00;
      t_rbase   = 8'h00;
      t_relem   = 8'h00;
      xfers     = 2'd0;
      starred   = 1'b0;
      is_string = 1'b0;
      is_cmp    = 1'b0;
      if (op[7:2] == 6'b001100) begin
         cls      = `LSB_CL_XOR_RM;
         t_single = mem ? `LSB_T_LOGIC_MEM : `LSB_T_LOGIC_REG;
         xfers    = mem ? (d_bit ? 2'd1 : 2'd2) : 2'd0;    // d=1: memory is only read
         starred  = 1'b1;
      end else if (op[7:1] == 7'b1000000 && ext == 3'b110) begin
         cls      = `LSB_CL_XOR_IRM;
         t_single = mem ? `LSB_T_IMM_MEM : `LSB_T_IMM_REG;
         xfers    = mem ? 2'd2 : 2'd0;
         starred  = 1'b1;
      end else if (op[7:1] == 7'b0011010) begin
         cls      = `LSB_CL_XOR_IACC;
         t_single = w_bit ? `LSB_T_ACC_WORD : `LSB_T_ACC_BYTE;
      end else if (op[7:1] == 7'b1111011 && ext == 3'b010) begin
         cls      = `LSB_CL_INVERT;
         t_single = mem ? `LSB_T_LOGIC_MEM : `LSB_T_LOGIC_REG;
         xfers    = mem ? 2'd2 : 2'd0;
         starred  = 1'b1;
      end else if (op[7:1] == 7'b1010010) begin
         cls = `LSB_CL_MOVE;
         t_single = `LSB_T_MOVE;
         t_rbase = `LSB_T_REP_MOVE_B;
         t_relem = `LSB_T_REP_MOVE_E;
         xfers = 2'd2;
         starred = 1'b1;
         is_string = 1'b1;
      end else if (op[7:1] == 7'b1010011) begin
         cls = `LSB_CL_COMPARE;
         t_single = `LSB_T_COMPARE;
         t_rbase = `LSB_T_REP_CMP_B;
         t_relem = `LSB_T_REP_CMP_E;
         xfers = 2'd2;
         starred = 1'b1;
         is_string = 1'b1;
         is_cmp = 1'b1;
      end else if (op[7:1] == 7'b1010111) begin
         cls = `LSB_CL_SCAN;
         t_single = `LSB_T_SCAN;
         t_rbase = `LSB_T_REP_CMP_B;
         t_relem = `LSB_T_REP_SCAN_E;
         xfers = 2'd1;
         starred = 1'b1;
         is_string = 1'b1;
         is_cmp = 1'b1;
      end else if (op[7:1] == 7'b1010110) begin
         cls = `LSB_CL_LOAD;
         t_single = `LSB_T_LOAD;
         t_rbase = `LSB_T_REP_LS_B;
         t_relem = `LSB_T_REP_LOAD_E;
         xfers = 2'd1;
         starred = 1'b1;
         is_string = 1'b1;
      end else if (op[7:1] == 7'b1010101) begin
         cls = `LSB_CL_STORE;
         t_single = `LSB_T_STORE;
         t_rbase = `LSB_T_REP_LS_B;
         t_relem = `LSB_T_REP_STORE_E;
         xfers = 2'd1;
         starred = 1'b1;
         is_string = 1'b1;
      end else if (op[7:1] == 7'b0110110) begin
         cls = `LSB_CL_INPUT;
         t_single = `LSB_T_INOUT;
         t_rbase = `LSB_T_REP_MOVE_B;
         t_relem = `LSB_T_REP_MOVE_E;
         is_string = 1'b1;
      end else if (op[7:1] == 7'b0110111) begin
         cls = `LSB_CL_OUTPUT;
         t_single = `LSB_T_INOUT;
         t_rbase = `LSB_T_REP_MOVE_B;
         t_relem = `LSB_T_REP_MOVE_E;
         is_string = 1'b1;
      end else if (op == 8'hFF && ext == 3'b010) begin
         cls = `LSB_CL_CALL_IND;
         if (narrow_r) begin
            t_single = mem ? `LSB_T_CALL_MEM_N : `LSB_T_CALL_REG_N;
         end else begin
            t_single = mem ? `LSB_T_CALL_MEM_W : `LSB_T_CALL_REG_W;
         end
      end else if (op == 8'hEB || op == 8'hE9) begin
         cls = (op == 8'hEB) ? `LSB_CL_JMP_SHORT : `LSB_CL_JMP_NEAR;
         t_single = `LSB_T_JMP;
      end else if (op == 8'hFF && ext == 3'b100) begin
         cls = `LSB_CL_JMP_IND;
         if (!mem) begin
            t_single = `LSB_T_JIND_REG;
         end else begin
            t_single = narrow_r ? `LSB_T_JIND_MEM_N : `LSB_T_JIND_MEM_W;
         end
      end
      // a prefix only makes sense as a repeat in front of a string opcode
      if (pfx_vld && (!is_string || pfx[7:1] != 7'b1111001)) begin
         cls = `LSB_CL_ILL;
      end
   end

   // word penalty on the narrow bus, per memory transfer
   always @* begin
      pen = 8'h00;
      if (narrow_r && w_bit && starred) begin
         pen = (xfers == 2'd2) ? (`LSB_T_WORD_XFER + `LSB_T_WORD_XFER)
             : (xfers == 2'd1) ? `LSB_T_WORD_XFER : 8'h00;
      end
      repeat_prefix      = pfx_vld & is_string;
      base_val = repeat_prefix ? t_rbase : (t_single + pen);
   end

   wire tm_last;
   wire elem_eq   = (elem_idx_r == eqidx_r);
   // z=1 repeats while equal, z=0 repeats while not equal
   wire term_hit  = run_z_r ? ~elem_eq : elem_eq;
   wire elem_end  = (state_r == ST_ELEM) & tm_last;
   wire count_end = (count_r == 16'h0001);
   // live decode is safe here: instr writes are refused until the run ends
   wire stop_term = is_cmp & term_hit;
   wire tm_load   = (start & (cls != `LSB_CL_ILL))
                  | ((state_r == ST_BASE) & tm_last & run_rep_r & (count_r != 16'h0000))
                  | (elem_end & ~count_end & ~stop_term);

   lsb_timer u_timer (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .load_i (tm_load),
      .val_i  ((state_r == ST_IDLE) ? base_val : run_elem_r),
      .last_o (tm_last)
   );

   // sequencer: overhead phase, then one timed phase per element
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (start && cls != `LSB_CL_ILL) begin
               state_nxt = ST_BASE;
            end
         end
         ST_BASE: begin
            if (tm_last) begin
               state_nxt = (run_rep_r && count_r != 16'h0000) ? ST_ELEM : ST_IDLE;
            end
         end
         ST_ELEM: begin
            if (tm_last && (count_end || stop_term)) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   // run state, flags and the live count
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_r     <= ST_IDLE;
         done_r      <= 1'b0;
         illegal_r   <= 1'b0;
         term_r      <= 1'b0;
         cycles_r    <= 32'h00000000;
         run_class_r <= `LSB_CL_ILL;
         run_rep_r   <= 1'b0;
         run_z_r     <= 1'b0;
         run_elem_r  <= 8'h00;
         elem_idx_r  <= 16'h0000;
         busy_o      <= 1'b0;
      end else begin
         state_r <= state_nxt;
         busy_o  <= (state_nxt != ST_IDLE);
         if (start) begin
            done_r      <= (cls == `LSB_CL_ILL);
            illegal_r   <= (cls == `LSB_CL_ILL);
            term_r      <= 1'b0;
            cycles_r    <= 32'h00000000;
            run_class_r <= cls;
            run_rep_r   <= repeat_prefix;
            run_z_r     <= pfx[0];
            run_elem_r  <= t_relem + pen;
            elem_idx_r  <= 16'h0000;
         end else begin
            if (state_r != ST_IDLE) begin
               cycles_r <= cycles_r + 32'h00000001;
            end
            if (state_r != ST_IDLE && state_nxt == ST_IDLE) begin
               done_r <= 1'b1;
            end
            if (elem_end) begin
               elem_idx_r <= elem_idx_r + 16'h0001;
               term_r     <= stop_term & ~count_end;
            end
         end
      end
   end

   // wishbone slave: one wait state, ack for one cycle, unmapped reads zero
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         narrow_r <= 1'b0;
         instr_r  <= `LSB_RST_INSTR;
         count_r  <= `LSB_RST_COUNT;
         eqidx_r  <= `LSB_RST_EQIDX;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= 32'h00000000;
         if (elem_end) begin
            count_r <= count_r - 16'h0001;
         end
         // configuration is frozen while an instruction runs
         if (wb_wr && state_r == ST_IDLE) begin
            if (wb_adr_i == `LSB_OFS_CTRL) begin
               if (wb_sel_i[0]) narrow_r <= wb_dat_i[`LSB_CTRL_NARROW];
            end else if (wb_adr_i == `LSB_OFS_INSTR) begin
               if (wb_sel_i[0]) instr_r[7:0]   <= wb_dat_i[7:0];
               if (wb_sel_i[1]) instr_r[15:8]  <= wb_dat_i[15:8];
               if (wb_sel_i[2]) instr_r[23:16] <= wb_dat_i[23:16];
               if (wb_sel_i[3]) instr_r[24]    <= wb_dat_i[24];
            end else if (wb_adr_i == `LSB_OFS_COUNT) begin
               if (wb_sel_i[0]) count_r[7:0]  <= wb_dat_i[7:0];
               if (wb_sel_i[1]) count_r[15:8] <= wb_dat_i[15:8];
            end else if (wb_adr_i == `LSB_OFS_EQIDX) begin
               if (wb_sel_i[0]) eqidx_r[7:0]  <= wb_dat_i[7:0];
               if (wb_sel_i[1]) eqidx_r[15:8] <= wb_dat_i[15:8];
            end
         end
         if (wb_req && !wb_we_i) begin
            if (wb_adr_i == `LSB_OFS_CTRL) begin
               wb_dat_o <= {30'h0, narrow_r, 1'b0};
            end else if (wb_adr_i == `LSB_OFS_INSTR) begin
               wb_dat_o <= {7'h00, instr_r};
            end else if (wb_adr_i == `LSB_OFS_COUNT) begin
               wb_dat_o <= {16'h0000, count_r};
            end else if (wb_adr_i == `LSB_OFS_EQIDX) begin
               wb_dat_o <= {16'h0000, eqidx_r};
            end else if (wb_adr_i == `LSB_OFS_STATUS) begin
               wb_dat_o <= {20'h00000, run_rep_r, d_bit, mem, w_bit, run_class_r,
                            term_r, illegal_r, done_r, (state_r != ST_IDLE)};
            end else if (wb_adr_i == `LSB_OFS_CYCLES) begin
               wb_dat_o <= cycles_r;
            end
         end
      end
   end
endmodule

`default_nettype wire

/* tb/lsb_chk.sv */
`include "lsb_defs.vh"
`default_nettype none

// passive watcher on the register bus and the busy line
module lsb_chk (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        busy_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // a request counts once: ack low means it is not yet answered
   wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire logic go  = req && wb_we_i && wb_adr_i == `LSB_OFS_CTRL && wb_sel_i[0] && wb_dat_i[0];
   wire logic rd  = wb_cyc_i && wb_stb_i && !wb_we_i;

   ack_one_a: assert property (req |=> wb_ack_o) else $error("request not acked next cycle");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
   ack_cause_a: assert property (wb_ack_o |-> $past(req)) else $error("ack without request");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   // busy rises together with the ack of the start write
   busy_cause_a: assert property ($rose(busy_o) |-> wb_ack_o && $past(go))
      else $error("busy rose without start");
   busy_min_a: assert property ($rose(busy_o) |-> busy_o [*3])
      else $error("busy shorter than three clocks");
   unmapped_zero_a: assert property (wb_ack_o && $past(rd && wb_adr_i > 8'h14)
      |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
   start_reads0_a: assert property (wb_ack_o && $past(rd && wb_adr_i == `LSB_OFS_CTRL)
      |-> !wb_dat_o[0]) else $error("start bit reads back set");

   // main scenarios reached
   cover property ($rose(busy_o));
   cover property ($fell(busy_o));
   cover property (wb_ack_o && $past(rd));
endmodule

bind lsb_decoder lsb_chk lsb_chk_inst (
   .clk_i    (clk_i),
   .rst_i    (rst_i),
   .wb_cyc_i (wb_cyc_i),
   .wb_stb_i (wb_stb_i),
   .wb_we_i  (wb_we_i),
   .wb_adr_i (wb_adr_i),
   .wb_sel_i (wb_sel_i),
   .wb_dat_i (wb_dat_i),
   .wb_dat_o (wb_dat_o),
   .wb_ack_o (wb_ack_o),
   .busy_o   (busy_o)
);
`default_nettype wire

/* tb/lsb_host.sv */
`default_nettype none

// software side: one classic bus cycle at a time
module lsb_host (
   input  wire logic        clk_i,
   input  wire logic        ack_i,
   input  wire logic [31:0] dat_i,
   output logic             cyc_o,
   output logic             stb_o,
   output logic             we_o,
   output logic [7:0]       adr_o,
   output logic [3:0]       sel_o,
   output logic [31:0]      dat_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle bus from time zero
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 8'h00;
      sel_o = 4'h0;
      dat_o = 32'h0;
   end

   // enter right after a rising edge; everything holds until ack is sampled
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic ok);
      int i;
      ok = 1'b0;
      rd = 32'h0;
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= we;
      adr_o <= adr;
      sel_o <= 4'hF;
      dat_o <= wd;
      for (i = 0; i < 40 && !ok; i++) begin
         @(posedge clk_i);
         if (ack_i === 1'b1) begin
            ok = 1'b1;
            rd = dat_i;
         end
      end
      // released data must not keep looking valid
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      we_o <= 1'b0;
      dat_o <= ~wd;
      @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

/* tb/lsb_decoder_bench.sv */
`include "lsb_defs.vh"
`default_nettype none

// self-checking run of the decoder through its register bus
module lsb_decoder_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc, stb, we, ack, busy;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat;
   int          n_errors = 0;
   int          check_count = 0;
   int          busy_n = 0;
   // string ops: opcode, single figure, repeat base, per element, memory transfers
   int          ops[7] = '{8'hA4, 8'hA6, 8'hAE, 8'hAC, 8'hAA, 8'h6C, 8'h6E};
   int          sg[7] = '{14, 22, 15, 12, 10, 14, 14};
   int          bs[7] = '{8, 5, 5, 6, 6, 8, 8};
   int          el[7] = '{8, 22, 15, 11, 9, 8, 8};
   int          xf[7] = '{2, 2, 1, 1, 1, 0, 0};

   always #5 clk_i = ~clk_i;

   // busy clocks seen on the pin, held against the timed figure
   always @(posedge clk_i) if (busy === 1'b1) busy_n <= busy_n + 1;

   lsb_host lsb_host_inst (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
      .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
   lsb_decoder lsb_decoder_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .busy_o(busy));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict;
      $display("checks=%0d errors=%0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // one bus cycle; a hung bus ends the run
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      logic ok;
      lsb_host_inst.xfer(w, a, d, r, ok);
      if (ok !== 1'b1) begin
         n_errors++;
         print_verdict();
      end
   endtask

   // expected {stopped early, count left, busy clocks} of a string op
   function automatic logic [31:0] str_exp(int k, logic w, logic rp, logic nar, logic z,
                                           int c, int e);
      int n;
      int pen;
      pen = (nar && w) ? 4 * xf[k] : 0;
      if (!rp)
         return {1'b0, 15'(c), 16'(sg[k] + pen)};
      n = c;
      if (k == 1 || k == 2)
         n = z ? ((e == 0) ? 2 : 1) : e + 1;
      if (n > c)
         n = c;
      return {n < c, 15'(c - n), 16'(bs[k] + n * (el[k] + pen))};
   endfunction

   // load, start, poll for done, then compare timing, status and count
   task automatic run(input logic [24:0] string_input, input logic nar, input int c, input int e,
                      input int t, input int cl, input logic ill, input int cx, input logic tm);
      logic [31:0] r;
      int b;
      int i;
      bus(1'b1, `LSB_OFS_COUNT, 32'(c), r);
      bus(1'b1, `LSB_OFS_EQIDX, 32'(e), r);
      bus(1'b1, `LSB_OFS_INSTR, {7'h00, string_input}, r);
      // width first: the start write decodes with the width already held
      bus(1'b1, `LSB_OFS_CTRL, {30'h0, nar, 1'b0}, r);
      b = busy_n;
      bus(1'b1, `LSB_OFS_CTRL, {30'h0, nar, 1'b1}, r);
      r = 32'h0;
      for (i = 0; i < 300 && r[1] !== 1'b1; i++)
         bus(1'b0, `LSB_OFS_STATUS, 32'h0, r);
      if (r[1] !== 1'b1) begin
         n_errors++;
         print_verdict();
      end
      chk(32'(busy_n - b), 32'(ill ? 0 : t));
      if (ill)
         chk(32'(r[2:0]), 32'h6);
      else
         chk(32'(r[11:0]), 32'({string_input[24], string_input[9], string_input[23:22] != 2'b11, string_input[8], 4'(cl), tm,
            3'b010}));
      bus(1'b0, `LSB_OFS_CYCLES, 32'h0, r);
      if (!ill)
         chk(r, 32'(t));
      bus(1'b0, `LSB_OFS_COUNT, 32'h0, r);
      chk(r, 32'(cx));
   endtask

   task automatic one(input logic [24:0] string_input, input logic nar, input int t, input int cl);
      run(string_input, nar, 0, 0, t, cl, 1'b0, 0, 1'b0);
   endtask

   initial begin
      logic [31:0] r;
      logic [31:0] x;
      logic        w, rp, nar, z;
      int          k, j, c, e;
      void'($urandom(92));
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      // the four writable registers leave reset cleared
      for (k = 0; k < 16; k += 4) begin
         bus(1'b0, 8'(k), 32'h0, r);
         chk(r, 32'h0);
      end
      // unmapped place: acked, write dropped, reads zero
      bus(1'b1, 8'h40, 32'hFFFFFFFF, r);
      bus(1'b0, 8'h40, 32'h0, r);
      chk(r, 32'h0);
      // fixed forms: {prefix valid, mode, opcode, prefix}
      one(25'h0C03100, 1'b1, 3, 1);
      one(25'h0063100, 1'b1, 18, 1);
      one(25'h0063300, 1'b1, 14, 1);
      one(25'h0063000, 1'b1, 10, 1);
      one(25'h0368100, 1'b1, 24, 2);
      one(25'h0F08000, 1'b0, 4, 2);
      one(25'h0003400, 1'b0, 3, 3);
      one(25'h0003500, 1'b1, 4, 3);
      one(25'h0D0F700, 1'b0, 3, 4);
      one(25'h016F700, 1'b1, 18, 4);
      one(25'h0D0FF00, 1'b0, 13, 12);
      one(25'h0D0FF00, 1'b1, 17, 12);
      one(25'h016FF00, 1'b0, 19, 12);
      one(25'h016FF00, 1'b1, 27, 12);
      one(25'h000EB00, 1'b1, 14, 13);
      one(25'h000E900, 1'b0, 14, 14);
      one(25'h0E0FF00, 1'b0, 11, 15);
      one(25'h026FF00, 1'b0, 17, 15);
      one(25'h026FF00, 1'b1, 21, 15);
      // unknown code, prefix on a jump, non-repeat prefix, unused extension
      run(25'h0000F00, 1'b0, 0, 0, 0, 0, 1'b1, 0, 1'b0);
      run(25'h100EBF2, 1'b0, 0, 0, 0, 0, 1'b1, 0, 1'b0);
      run(25'h100A490, 1'b0, 0, 0, 0, 0, 1'b1, 0, 1'b0);
      run(25'h0F8FF00, 1'b0, 0, 0, 0, 0, 1'b1, 0, 1'b0);
      // random string ops, single and repeated, both bus widths
      for (j = 0; j < 40; j++) begin
         k = $urandom % 7;
         w = 1'($urandom);
         rp = 1'($urandom);
         nar = 1'($urandom);
         z = 1'($urandom);
         c = $urandom % 6;
         e = $urandom % 6;
         x = str_exp(k, w, rp, nar, z, c, e);
         run({rp, 8'h00, 8'(ops[k]) | {7'h00, w}, 7'h79, z}, nar, c, e, int'(x[15:0]), 5 + k,
             1'b0, int'(x[30:16]), x[31]);
      end
      print_verdict();
   end
endmodule
`default_nettype wire
